// ==== bench/sst_partner.sv ====
// Far-side model: a test engine that answers test_start and a display that takes commands.
// Assumes one clock shared with the sequencer; the bench sets fail_num, fail_hit and slow.
`timescale 1ns/1ps
module sst_partner import sst_pkg::*; (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       test_start,
  input  wire logic [3:0] test_num,
  input  wire logic [3:0] fail_num,
  input  wire logic [3:0] fail_hit,
  input  wire logic       slow,
  output sst_test_res_t   test_res,
  output logic            disp_ready
);
  logic [7:0] cyc = 8'h00;
  logic [3:0] wait_cnt;
  logic [3:0] hits;
  logic [3:0] num;
  logic       busy;

  // A slow display stalls every other cycle, so commands must stand until taken.
  assign disp_ready = slow ? cyc[0] : 1'b1;

  always_ff @(posedge clk) begin
    cyc <= cyc + 8'h01;
    // Outside done the result fields change every cycle, so stale values cannot pass.
    test_res <= '{1'b0, cyc[0], ~cyc[0], cyc};
    if (!nrst) begin
      busy <= 1'b0;
      hits <= 4'h0;
    end else if (test_start) begin
      busy     <= 1'b1;
      num      <= test_num;
      wait_cnt <= slow ? 4'h9 : 4'h2;
      if (test_num == fail_num) hits <= hits + 4'h1;
    end else if (busy) begin
      if (wait_cnt == 4'h0) begin
        busy     <= 1'b0;
        test_res <= '{1'b1, hits == fail_hit && num == fail_num, num == 4'h6, {num, 4'h1}};
      end
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule

// ==== bench/tb_sst_seq.sv ====
// Self-checking bench for the self-test sequencer with a far-side model.
// Assumes short window and blink counts; one 125 MHz clock drives everything.
`timescale 1ns/1ps
module tb_sst_seq import sst_pkg::*;;
  localparam int unsigned WIN = 50;
  localparam int unsigned BLK = 20;
  // Revision word for the ID line; the value is arbitrary.
  localparam logic [15:0] REV = 16'h5a3c;
  logic          clk, nrst, key_valid, disp_ready, test_start, disp_valid;
  logic          lock_led, load_allow, load_inhibit, slow;
  logic [7:0]    key_code, sw_bank07, sw_bank08;
  logic [3:0]    test_num, fail_num, fail_hit;
  logic [4:0]    led_fn;
  logic [31:0]   lfsr;
  sst_test_res_t test_res;
  sst_disp_cmd_t disp_cmd;
  sst_disp_cmd_t dq[$];
  logic [3:0]    tq[$];
  logic [15:0]   got[$];
  logic [15:0]   exp_q[$];
  int            num_errors, total_checks, clears, clr_at[16];

  sst_seq #(.WIN_CYC(WIN), .BLINK_CYC(BLK), .TEST_REV(REV)) DUT (
    .clk(clk), .nrst(nrst), .key_valid(key_valid), .key_code(key_code),
    .sw_bank07(sw_bank07), .sw_bank08(sw_bank08), .test_res(test_res),
    .disp_ready(disp_ready), .test_start(test_start), .test_num(test_num),
    .disp_valid(disp_valid), .disp_cmd(disp_cmd), .led_fn(led_fn), .lock_led(lock_led),
    .load_allow(load_allow), .load_inhibit(load_inhibit));

  sst_partner u_partner (
    .clk(clk), .nrst(nrst), .test_start(test_start), .test_num(test_num),
    .fail_num(fail_num), .fail_hit(fail_hit), .slow(slow), .test_res(test_res),
    .disp_ready(disp_ready));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Record every started test and every display command the display took.
  always @(posedge clk) if (nrst === 1'b1) begin
    if (test_start === 1'b1) begin
      tq.push_back(test_num);
      clr_at[test_num] = clears;
    end
    if (disp_valid === 1'b1 && disp_ready === 1'b1) begin
      dq.push_back(disp_cmd);
      if (disp_cmd.op === DOP_CLEAR) clears++;
    end
    if (test_res.done === 1'b1) check(led_fn[3:0], test_num);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic start(input logic [3:0] fn, input logic [3:0] fh, input logic sl);
    nrst = 1'b0;
    fail_num = fn;
    fail_hit = fh;
    slow = sl;
    lfsr = next_rand(lfsr);
    sw_bank07 = lfsr[7:0];
    sw_bank08 = lfsr[15:8];
    tick(4);
    tq.delete();
    dq.delete();
    clears = 0;
    nrst = 1'b1;
  endtask

  // The code line is inverted after the strobe so a stale code is never seen as fresh.
  task automatic send_key(input logic [7:0] code);
    key_valid = 1'b1;
    key_code = code;
    tick(1);
    key_valid = 1'b0;
    key_code = ~code;
    tick(8);
  endtask

  task automatic wait_end(input int bound);
    int n;
    n = 0;
    while (load_allow !== 1'b1 && load_inhibit !== 1'b1 && n < bound) begin
      tick(1);
      n++;
    end
    tick(30);
  endtask

  task automatic check_seq(input int lo, input int hi, input int reps, input int tail);
    int q[$];
    for (int r = 0; r <= reps; r++)
      for (int t = lo; t <= ((r == reps) ? tail : hi); t++) q.push_back(t);
    check(tq.size(), q.size());
    foreach (q[i]) if (i < tq.size()) check(tq[i], q[i]);
  endtask

  task automatic args_of(input sst_disp_op_t op);
    got.delete();
    foreach (dq[i]) if (dq[i].op === op) got.push_back(dq[i].arg0);
    check(got.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got.size()) check(got[i], exp_q[i]);
  endtask

  task automatic halt_check(input logic [3:0] num);
    int n;
    logic prev;
    n = 0;
    prev = lock_led;
    check(load_inhibit, 1'b1);
    check(load_allow, 1'b0);
    check(led_fn[3:0], num);
    repeat (4 * BLK) begin
      tick(1);
      if (lock_led !== prev) n++;
      prev = lock_led;
    end
    check(n >= 3 && n <= 5, 1'b1);
  endtask

  task automatic select(input logic [7:0] code);
    tick(5);
    send_key(KEY_CANCEL);
    send_key(code);
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    {nrst, key_valid, key_code, sw_bank07, sw_bank08} = '0;
    {fail_num, fail_hit, slow, num_errors, total_checks} = '0;
    lfsr = 32'h525664a9;
    // Normal mode, every test passes, slow far side.
    start(4'h0, 4'h0, 1'b1);
    tick(10);
    check(led_fn, LED_WIN1);
    tick(WIN - 15);
    check(tq.size(), 0);
    wait_end(3000);
    check(load_allow, 1'b1);
    check(load_inhibit, 1'b0);
    check(lock_led, 1'b0);
    check(led_fn, LED_OFF);
    check_seq(2, 8, 0, 8);
    check(dq[0].op, DOP_CLEAR);
    check(dq[1].op, DOP_ID);
    check(dq[1].arg0, REV);
    check(dq[1].arg1, {sw_bank07, sw_bank08});
    check(clr_at[2], 1);
    check(clr_at[7] - clr_at[6], 1);
    // Cancel, ignored codes, second window runs out, then test 5 fails.
    start(4'h5, 4'h1, 1'b0);
    tick(30);
    send_key(KEY_CANCEL);
    check(led_fn, LED_WIN2);
    send_key({1'b1, KEY_INDENT[6:0]});
    send_key(8'h0e);
    tick(WIN - 30);
    check(tq.size(), 0);
    wait_end(3000);
    check_seq(2, 8, 0, 5);
    check(dq[$].op, DOP_ERR);
    check(dq[$].arg0, 16'h0051);
    check(dq[$].arg1, 16'h0005);
    check(dq[$-1].op, DOP_ID);
    check(dq[$-2].op, DOP_CLEAR);
    halt_check(4'h5);
    // Skip mode.
    start(4'h0, 4'h0, 1'b0);
    select(KEY_INDENT);
    check(load_allow, 1'b1);
    check(tq.size(), 0);
    // Loop mode, failure on the third pass through test 3.
    start(4'h3, 4'h3, 1'b0);
    select(KEY_PAGE);
    wait_end(5000);
    check_seq(2, 8, 2, 3);
    halt_check(4'h3);
    // Video mode: patterns cycle, a stray mode key is ignored, help releases.
    start(4'h0, 4'h0, 1'b1);
    select(KEY_CENTER);
    repeat (4) begin
      tick(12);
      send_key(KEY_CENTER);
    end
    send_key(KEY_INDENT);
    tick(10);
    check(load_allow, 1'b0);
    send_key(KEY_HELP);
    wait_end(40);
    check(load_allow, 1'b1);
    check(tq.size(), 0);
    exp_q = '{16'h0, 16'h1, 16'h2, 16'h0, 16'h1};
    args_of(DOP_PATTERN);
    // External loopback, failure on the fourth run.
    start(4'h9, 4'h4, 1'b0);
    select(KEY_FORMAT);
    wait_end(3000);
    check_seq(9, 9, 3, 9);
    check(dq[$].op, DOP_ERR);
    check(dq[$].arg1, 16'h0009);
    exp_q.delete();
    foreach (dq[i]) if (dq[i].op === DOP_PASS_CNT) exp_q.push_back(dq[i].arg0);
    check(exp_q[0], 16'h0000);
    check(exp_q[$], 16'h0003);
    halt_check(4'h9);
    // Keyboard echo with random codes; reserved codes must not show.
    start(4'h0, 4'h0, 1'b0);
    select(KEY_SEARCH);
    tick(20);
    exp_q.delete();
    repeat (12) begin
      lfsr = next_rand(lfsr);
      if (lfsr[7:0] > KEY_RESERVED_TOP) exp_q.push_back({8'h00, lfsr[7:0]});
      send_key(lfsr[7:0] & (lfsr[8] ? 8'hff : 8'h0f));
      if (lfsr[8] == 1'b0 && lfsr[7:0] > KEY_RESERVED_TOP) void'(exp_q.pop_back());
    end
    check(dq[0].op, DOP_CLEAR);
    args_of(DOP_KEY_HEX);
    check(tq.size(), 0);
    wrap_up();
  end
endmodule

// ==== design/sst_pkg.sv ====
// Shared constants, enumerations and carrier types for the power-up self-test sequencer.
// Assumes a single 125 MHz system clock for every user of these definitions.
package sst_pkg;

  localparam int unsigned CLK_KHZ        = 125000;
  localparam int unsigned WINDOW_MS      = 2000;
  localparam int unsigned WINDOW_CYC     = WINDOW_MS * CLK_KHZ;
  // Half of a blink period; about 1.5 blinks per second.
  localparam int unsigned BLINK_HALF_MS  = 333;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
  localparam int unsigned CNT_W          = 28;

  localparam logic [7:0] KEY_RESERVED_TOP = 8'h0f;
  localparam int unsigned KEY_BREAK_BIT   = 7;
  localparam logic [7:0] KEY_CANCEL       = 8'h12;
  localparam logic [7:0] KEY_INDENT       = 8'h7e;
  localparam logic [7:0] KEY_PAGE         = 8'h7d;
  localparam logic [7:0] KEY_CENTER       = 8'h7c;
  localparam logic [7:0] KEY_FORMAT       = 8'h7a;
  localparam logic [7:0] KEY_SEARCH       = 8'h76;
  localparam logic [7:0] KEY_HELP         = 8'h36;

  localparam logic [3:0] TEST_FIRST    = 4'h2;
  localparam logic [3:0] TEST_LAST     = 4'h8;
  localparam logic [3:0] TEST_LOOPBACK = 4'h9;
  localparam logic [1:0] PAT_LAST      = 2'h2;

  localparam logic [4:0] LED_OFF  = 5'h00;
  localparam logic [4:0] LED_WIN1 = 5'h01;
  localparam logic [4:0] LED_WIN2 = 5'h10;

  typedef enum logic [2:0] {
    MODE_NORMAL, MODE_SKIP, MODE_LOOP, MODE_VIDEO, MODE_LOOPBACK, MODE_ECHO
  } sst_mode_t;

  typedef enum {
    ST_WIN1, ST_WIN2, ST_SHOW, ST_TEST_GO, ST_TEST_WAIT, ST_VIDEO, ST_ECHO, ST_HALT, ST_RELEASE
  } sst_state_t;

  typedef enum logic [1:0] {STP_CLEAR, STP_ID, STP_CNT, STP_ERR} sst_step_t;

  typedef enum logic [2:0] {
    DOP_CLEAR, DOP_ID, DOP_PASS_CNT, DOP_ERR, DOP_KEY_HEX, DOP_PATTERN
  } sst_disp_op_t;

  typedef struct packed {
    sst_disp_op_t op;
    logic [15:0]  arg0;
    logic [15:0]  arg1;
  } sst_disp_cmd_t;

  typedef struct packed {
    logic       done;
    logic       fail;
    logic       screen_dirty;
    logic [7:0] err_code;
  } sst_test_res_t;

  function automatic logic is_reserved(input logic [7:0] code);
    return code <= KEY_RESERVED_TOP;
  endfunction

  function automatic logic is_make(input logic [7:0] code);
    return !is_reserved(code) && !code[KEY_BREAK_BIT];
  endfunction

endpackage

// ==== design/sst_seq.sv ====
// Power-up self-test sequencer: mode selection, test stepping, LEDs, screen and load release.
// Assumes key codes, test results and display ready come from logic on clk; switch
// banks are pins and are synchronised here.
`timescale 1ns/1ps

module sst_seq import sst_pkg::*; #(
  parameter int unsigned WIN_CYC   = WINDOW_CYC,
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC,
  // Revision shown on the ID line; the value is arbitrary.
  parameter logic [15:0] TEST_REV  = 16'h0100
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          key_valid,
  input  wire logic [7:0]    key_code,
  input  wire logic [7:0]    sw_bank07,
  input  wire logic [7:0]    sw_bank08,
  input  wire sst_test_res_t test_res,
  input  wire logic          disp_ready,
  output logic               test_start,
  output logic [3:0]         test_num,
  output logic               disp_valid,
  output sst_disp_cmd_t      disp_cmd,
  output logic [4:0]         led_fn,
  output logic               lock_led,
  output logic               load_allow,
  output logic               load_inhibit
);

  sst_state_t  state;
  sst_mode_t   mode;
  sst_step_t   step;
  logic        failed;
  logic [7:0]  err_code;
  logic [15:0] pass_count;
  logic [1:0]  pat_idx;
  logic        pat_pend;
  logic [7:0]  echo_code;
  logic        echo_pend;
  logic [15:0] sw_sync;
  logic        win_exp;
  logic        blink_tick;

  // Selection only reacts to make codes, so shift break codes never pick a mode.
  wire logic make      = key_valid && is_make(key_code);
  wire logic k_cancel  = make && key_code == KEY_CANCEL;
  wire logic k_indent  = make && key_code == KEY_INDENT;
  wire logic k_page    = make && key_code == KEY_PAGE;
  wire logic k_center  = make && key_code == KEY_CENTER;
  wire logic k_format  = make && key_code == KEY_FORMAT;
  wire logic k_search  = make && key_code == KEY_SEARCH;
  wire logic k_help    = make && key_code == KEY_HELP;
  wire logic k_echo    = key_valid && !is_reserved(key_code);
  wire logic disp_free = !disp_valid || disp_ready;
  wire logic win_start = state == ST_WIN1 && k_cancel;
  wire logic pass_ok   = state == ST_TEST_WAIT && test_res.done && !test_res.fail;

  sst_sync2 #(.W(16)) u_sw_sync (
    .clk  (clk),
    .nrst (nrst),
    .d    ({sw_bank07, sw_bank08}),
    .q    (sw_sync)
  );

  sst_timer #(.LIMIT(WIN_CYC)) u_win_timer (
    .clk     (clk),
    .nrst    (nrst),
    .restart (win_start),
    .tick    (win_exp)
  );

  sst_timer #(.LIMIT(BLINK_CYC)) u_blink_timer (
    .clk     (clk),
    .nrst    (nrst),
    .restart (state != ST_HALT),
    .tick    (blink_tick)
  );

  function automatic sst_state_t after_show(input logic f, input sst_mode_t m);
    if (f) begin
      return ST_HALT;
    end else if (m == MODE_VIDEO) begin
      return ST_VIDEO;
    end else if (m == MODE_ECHO) begin
      return ST_ECHO;
    end
    return ST_TEST_GO;
  endfunction

  function automatic sst_disp_cmd_t mk_cmd(input sst_disp_op_t op, input logic [15:0] a0,
                                           input logic [15:0] a1);
    sst_disp_cmd_t c;
    c.op   = op;
    c.arg0 = a0;
    c.arg1 = a1;
    return c;
  endfunction

  // Main sequence. No state leads back to selection, so a chosen mode holds until reset.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state      <= ST_WIN1;
      mode       <= MODE_NORMAL;
      step       <= STP_CLEAR;
      test_num   <= TEST_FIRST;
      test_start <= 1'b0;
      failed     <= 1'b0;
      err_code   <= 8'h00;
      disp_valid <= 1'b0;
      disp_cmd   <= '0;
      pat_idx    <= 2'h0;
      pat_pend   <= 1'b0;
      echo_code  <= 8'h00;
      echo_pend  <= 1'b0;
    end else begin
      test_start <= 1'b0;
      if (disp_valid && disp_ready) begin
        disp_valid <= 1'b0;
      end
      unique case (state)
        ST_WIN1: begin
          if (k_cancel) begin
            state <= ST_WIN2;
          end else if (win_exp) begin
            mode  <= MODE_NORMAL;
            state <= ST_SHOW;
          end
        end
        ST_WIN2: begin
          if (k_indent) begin
            mode  <= MODE_SKIP;
            state <= ST_RELEASE;
          end else if (k_page) begin
            mode  <= MODE_LOOP;
            state <= ST_SHOW;
          end else if (k_center) begin
            mode     <= MODE_VIDEO;
            pat_pend <= 1'b1;
            state    <= ST_SHOW;
          end else if (k_format) begin
            mode     <= MODE_LOOPBACK;
            test_num <= TEST_LOOPBACK;
            state    <= ST_SHOW;
          end else if (k_search) begin
            mode  <= MODE_ECHO;
            state <= ST_SHOW;
          end else if (win_exp) begin
            mode  <= MODE_NORMAL;
            state <= ST_SHOW;
          end
        end
        ST_SHOW: begin
          // Screen rebuild: clear, ID line, pass count in loopback, error line after a fault.
          if (disp_free) begin
            disp_valid <= 1'b1;
            unique case (step)
              STP_CLEAR: begin
                disp_cmd <= mk_cmd(DOP_CLEAR, 16'h0000, 16'h0000);
                step     <= STP_ID;
              end
              STP_ID: begin
                disp_cmd <= mk_cmd(DOP_ID, TEST_REV, sw_sync);
                if (mode == MODE_LOOPBACK) begin
                  step <= STP_CNT;
                end else if (failed) begin
                  step <= STP_ERR;
                end else begin
                  step  <= STP_CLEAR;
                  state <= after_show(failed, mode);
                end
              end
              STP_CNT: begin
                disp_cmd <= mk_cmd(DOP_PASS_CNT, pass_count, 16'h0000);
                if (failed) begin
                  step <= STP_ERR;
                end else begin
                  step  <= STP_CLEAR;
                  state <= after_show(failed, mode);
                end
              end
              STP_ERR: begin
                disp_cmd <= mk_cmd(DOP_ERR, {8'h00, err_code}, {12'h000, test_num});
                step     <= STP_CLEAR;
                state    <= after_show(failed, mode);
              end
            endcase
          end
        end
        ST_TEST_GO: begin
          test_start <= 1'b1;
          state      <= ST_TEST_WAIT;
        end
        ST_TEST_WAIT: begin
          if (test_res.done && test_res.fail) begin
            failed   <= 1'b1;
            err_code <= test_res.err_code;
            step     <= STP_CLEAR;
            state    <= ST_SHOW;
          end else if (test_res.done) begin
            step  <= test_res.screen_dirty ? STP_CLEAR : STP_CNT;
            state <= ST_TEST_GO;
            if (mode == MODE_LOOPBACK) begin
              state <= ST_SHOW;
            end else if (test_num == TEST_LAST) begin
              if (mode == MODE_LOOP) begin
                test_num <= TEST_FIRST;
                step     <= STP_CLEAR;
                if (test_res.screen_dirty) begin
                  state <= ST_SHOW;
                end
              end else begin
                state <= ST_RELEASE;
              end
            end else begin
              test_num <= 4'(test_num + 4'h1);
              step     <= STP_CLEAR;
              if (test_res.screen_dirty) begin
                state <= ST_SHOW;
              end
            end
          end
        end
        ST_VIDEO: begin
          if (k_help) begin
            state <= ST_RELEASE;
          end else begin
            if (pat_pend && disp_free) begin
              disp_valid <= 1'b1;
              disp_cmd   <= mk_cmd(DOP_PATTERN, {14'h0000, pat_idx}, 16'h0000);
              pat_pend   <= 1'b0;
            end
            if (k_center) begin
              pat_idx  <= (pat_idx == PAT_LAST) ? 2'h0 : 2'(pat_idx + 2'h1);
              pat_pend <= 1'b1;
            end
          end
        end
        ST_ECHO: begin
          // One code can wait for the display; a second arriving meanwhile replaces it.
          if (echo_pend && disp_free) begin
            disp_valid <= 1'b1;
            disp_cmd   <= mk_cmd(DOP_KEY_HEX, {8'h00, echo_code}, 16'h0000);
            echo_pend  <= 1'b0;
          end
          if (k_echo) begin
            echo_code <= key_code;
            echo_pend <= 1'b1;
          end
        end
        ST_HALT, ST_RELEASE: begin
          state <= state;
        end
      endcase
    end
  end

  // The loopback pass count only advances on a pass, so it freezes at the first failure.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pass_count <= 16'h0000;
    end else if (pass_ok && mode == MODE_LOOPBACK) begin
      pass_count <= 16'(pass_count + 16'h0001);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      led_fn <= LED_OFF;
    end else begin
      unique case (state)
        ST_WIN1:                            led_fn <= LED_WIN1;
        ST_WIN2:                            led_fn <= LED_WIN2;
        ST_SHOW, ST_TEST_GO, ST_TEST_WAIT: begin
          led_fn <= (mode inside {MODE_VIDEO, MODE_ECHO}) ? LED_OFF : {1'b0, test_num};
        end
        ST_HALT:                            led_fn <= {1'b0, test_num};
        ST_VIDEO, ST_ECHO, ST_RELEASE:      led_fn <= LED_OFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_led <= 1'b0;
    end else if (state != ST_HALT) begin
      lock_led <= 1'b0;
    end else if (blink_tick) begin
      lock_led <= !lock_led;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      load_allow   <= 1'b0;
      load_inhibit <= 1'b0;
    end else begin
      load_allow   <= state == ST_RELEASE;
      load_inhibit <= failed;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_win1_timeout: assert property (
    state == ST_WIN1 && win_exp && !k_cancel |=> state == ST_SHOW && mode == MODE_NORMAL)
    else $error("First window expiry did not start normal mode.");
  a_cancel_opens: assert property (
    win_start |=> state == ST_WIN2 ##1 state == ST_WIN2 || mode != MODE_NORMAL || state == ST_SHOW)
    else $error("Cancel did not open the second window.");
  a_win2_default: assert property (
    state == ST_WIN2 && win_exp && !make |=> state == ST_SHOW && mode == MODE_NORMAL)
    else $error("Second window expiry did not fall back to normal mode.");
  a_test_range: assert property (
    test_start && mode != MODE_LOOPBACK |-> test_num >= TEST_FIRST && test_num <= TEST_LAST)
    else $error("Test number out of the normal sequence.");
  a_fail_stops: assert property (
    failed |-> !test_start && !load_allow)
    else $error("Testing or load continued after a failure.");
  a_skip_release: assert property (
    state == ST_WIN2 && k_indent |=> state == ST_RELEASE ##1 load_allow && !test_start)
    else $error("Skip did not release the unit for load.");
  a_pattern_step: assert property (
    state == ST_VIDEO && k_center && !k_help
      |=> pat_idx == (($past(pat_idx) == PAT_LAST) ? 2'h0 : 2'($past(pat_idx) + 2'h1)))
    else $error("Video pattern did not step cyclically.");
  a_help_exit: assert property (
    state == ST_VIDEO && k_help |=> state == ST_RELEASE ##1 load_allow)
    else $error("Help did not leave video mode for load.");
  a_count_freeze: assert property (
    failed |=> $stable(pass_count))
    else $error("Pass count moved after a failure.");
  a_win1_leds: assert property (
    state == ST_WIN1 && $past(nrst) && $past(state) == ST_WIN1 |-> led_fn == LED_WIN1)
    else $error("First window LED pattern wrong.");
  a_halt_leds: assert property (
    state == ST_HALT && $past(state) == ST_HALT |-> led_fn == {1'b0, test_num})
    else $error("Failed test number not held on LEDs.");
  a_reserved_drop: assert property (
    state == ST_WIN1 && key_valid && is_reserved(key_code) && !win_exp |=> state == ST_WIN1)
    else $error("Reserved code acted as a key press.");

  c_skip: cover property (state == ST_WIN2 && k_indent);
  c_loop_wrap: cover property (mode == MODE_LOOP && pass_ok && test_num == TEST_LAST);
  c_loopback_fail: cover property (mode == MODE_LOOPBACK && state == ST_HALT);
  c_echo_shown: cover property (state == ST_ECHO && disp_valid && disp_ready);

endmodule

// ==== design/sst_sync2.sv ====
// Two-flop synchroniser for a bus of slowly changing pin levels.
// Assumes each bit is a static level such as a switch; bits are not coherent as a word.
`timescale 1ns/1ps
module sst_sync2 #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ==== design/sst_timer.sv ====
// Free-running interval counter with a synchronous restart and a registered tick.
// Assumes LIMIT is at least two and fits in CNT_W bits.
`timescale 1ns/1ps
module sst_timer import sst_pkg::*; #(
  parameter int unsigned LIMIT = WINDOW_CYC
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic restart,
  output logic      tick
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

  logic [CNT_W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      // A restart also kills a tick that would land in the same cycle.
      tick <= !restart && cnt == LAST;
      if (restart || cnt == LAST) begin
        cnt <= '0;
      end else begin
        cnt <= CNT_W'(cnt + 1'b1);
      end
    end
  end

endmodule
